/* File: fpeg_top.sv */
// Flash program/erase gating: control bits, overlay emulation protection,
// interrupt masking, error protection and the external programmer port.
// Assumes an APB master on pclk and a flash array answering in one cycle.
// Notes on behaviour
// - Program or erase bit blocks interrupt input.
// - Reset, standby, pin low, no enable clear bits.
// - Emulation select protects all blocks from program/erase.
// - Erase never reaches the overlaid RAM contents.
// - Boot mode masks interrupt until RAM branch.
// - Error protection state also blocks interrupt.
// - Core array reads during program/erase return the erased byte.
// - Programmer mode offers read, write, total erase.
// - No identification readout in programmer mode.
// - Array starts out erased.
// - Three-bit field picks overlaid flash block.
// - Core array read during program/erase sets error flag.
module fpeg_top
    import fpeg_pkg::*;
#(
    parameter int ADDR_W = 17,
    parameter int DATA_W = 8
) (
    // Clock and reset.
    input  wire logic                       pclk,
    input  wire logic                       presetn,
    // APB slave.
    input  wire logic                       psel,
    input  wire logic                       penable,
    input  wire logic                       pwrite,
    input  wire logic [7:0]                 paddr,
    input  wire logic [31:0]                pwdata,
    output logic      [31:0]                prdata,
    output logic                            pready,
    output logic                            pslverr,
    // Pins.
    input  wire logic                       flash_write_enable_pin,
    input  wire logic                       nmi_pin,
    input  wire logic                       boot_mode_pin,
    input  wire logic                       prom_mode_pin,
    // Core side.
    input  wire logic                       standby_req,
    input  wire logic                       boot_branch_done,
    input  wire logic                       core_flash_read,
    input  wire logic [DATA_W-1:0]          array_rdata,
    output logic      [DATA_W-1:0]          core_flash_rdata,
    output logic                            nmi_to_core,
    output logic                            irq,
    // Array control.
    output logic                            program_active,
    output logic                            erase_active,
    output logic                            overlay_enable,
    output logic      [FPEG_OVL_SEL_W-1:0]  overlap_block_select,
    output logic                            array_read,
    output logic                            array_write,
    output logic                            array_erase_all,
    output logic      [ADDR_W-1:0]          array_addr,
    output logic      [DATA_W-1:0]          array_wdata,
    // External programmer port.
    input  wire logic                       prom_req,
    input  wire logic [1:0]                 prom_op,
    input  wire logic [ADDR_W-1:0]          prom_addr,
    input  wire logic [DATA_W-1:0]          prom_wdata,
    output logic      [DATA_W-1:0]          prom_rdata,
    output logic                            prom_done
);
    import fpeg_pkg::*;

    // The array path is byte wide and needs at least a byte of address.
    if (ADDR_W < 8 || ADDR_W > 24 || DATA_W != 8)
    begin : g_bad_param
        $error("fpeg_top: unsupported ADDR_W or DATA_W.");
    end

    typedef struct packed {
        logic                      software_write_enable;
        logic                      prog;
        logic                      erase;
        logic                      emul_sel;
        logic [FPEG_OVL_SEL_W-1:0] ovl_sel;
        logic                      err_flag;
        logic                      boot_branched;
        logic [FPEG_IRQ_W-1:0]     irq_stat;
        logic [FPEG_IRQ_W-1:0]     irq_en;
        logic                      irq;
        logic                      nmi_out;
        logic [31:0]               prdata;
        logic                      pready;
        logic                      pslverr;
        fpeg_prom_state_t          prom_st;
        logic [1:0]                prom_op;
        logic                      prog_act;
        logic                      erase_act;
        logic                      arr_rd;
        logic                      arr_wr;
        logic                      arr_erase;
        logic [ADDR_W-1:0]         arr_addr;
        logic [DATA_W-1:0]         arr_wdata;
        logic [DATA_W-1:0]         prom_rdata;
        logic                      prom_done;
        logic [DATA_W-1:0]         core_rdata;
    } fpeg_state_t;

    fpeg_state_t state_reg;
    fpeg_state_t state_next;

    logic [3:0] pins_sync;
    logic       fwe_s;
    logic       nmi_s;
    logic       boot_s;
    logic       prom_s;

    fpeg_sync #(
        .WIDTH (4)
    ) u_sync (
        .pclk     (pclk),
        .presetn  (presetn),
        .async_in ({prom_mode_pin, boot_mode_pin, nmi_pin, flash_write_enable_pin}),
        .sync_out (pins_sync)
    );

    assign fwe_s  = pins_sync[0];
    assign nmi_s  = pins_sync[1];
    assign boot_s = pins_sync[2];
    assign prom_s = pins_sync[3];

    logic setup_ph;
    logic access_ph;
    logic wr_ctrl;
    logic wr_ovl;
    logic wr_clr;
    logic wr_en;
    logic force_clr;
    logic err_set;
    logic boot_int;
    logic nmi_mask;
    logic [31:0] rd_val;
    logic        rd_err;
    logic [FPEG_IRQ_W-1:0] irq_ev;

    always_comb
    begin
        state_next = state_reg;
        setup_ph   = psel && !penable;
        access_ph  = psel && penable && state_reg.pready;
        wr_ctrl    = access_ph && pwrite && (paddr == FPEG_OFF_CTRL);
        wr_ovl     = access_ph && pwrite && (paddr == FPEG_OFF_OVERLAY);
        wr_clr     = access_ph && pwrite && (paddr == FPEG_OFF_IRQ_CLR);
        wr_en      = access_ph && pwrite && (paddr == FPEG_OFF_IRQ_EN);
        rd_val     = 32'h0000_0000;
        rd_err     = 1'b0;
        irq_ev     = '0;

        // Software control bits.
        if (wr_ctrl)
        begin
            state_next.software_write_enable   = pwdata[FPEG_CTRL_SWE_BIT];
            state_next.prog  = pwdata[FPEG_CTRL_PROG_BIT];
            state_next.erase = pwdata[FPEG_CTRL_ERASE_BIT];
        end
        if (wr_ovl)
        begin
            state_next.emul_sel = pwdata[FPEG_OVL_EMUL_BIT];
            state_next.ovl_sel  = pwdata[FPEG_OVL_SEL_LSB +: FPEG_OVL_SEL_W];
        end

        // Program and erase bits fall on standby, pin low or enable low.
        force_clr = standby_req || !fwe_s || !state_next.software_write_enable;
        if (force_clr)
        begin
            if (state_next.prog || state_next.erase)
            begin
                irq_ev[FPEG_IRQ_FORCE_BIT] = 1'b1;
            end
            state_next.prog  = 1'b0;
            state_next.erase = 1'b0;
        end

        // A core array read while a bit is set enters error protection; programmer reads do not.
        err_set = core_flash_read && (state_reg.prog || state_reg.erase);
        if (err_set && !state_reg.err_flag)
        begin
            irq_ev[FPEG_IRQ_ERR_BIT] = 1'b1;
        end
        if (err_set)
        begin
            state_next.err_flag = 1'b1;
        end

        // Modes are entered only without emulation select or error; the
        // overlaid RAM is not part of the array, so erase never touches it.
        state_next.prog_act  = state_next.prog && !state_next.emul_sel
                               && !state_next.err_flag;
        state_next.erase_act = state_next.erase && !state_next.emul_sel
                               && !state_next.err_flag;

        // Boot interval lasts until the branch into RAM.
        if (boot_branch_done)
        begin
            state_next.boot_branched = 1'b1;
        end
        boot_int = boot_s && !state_next.boot_branched;

        // Mask is built from next values so the output follows at once.
        nmi_mask = state_next.prog || state_next.erase
                   || boot_int
                   || state_next.err_flag;
        state_next.nmi_out = nmi_s && !nmi_mask;

        // Core read data is not the array while a bit is set.
        if (state_reg.prog || state_reg.erase)
        begin
            state_next.core_rdata = FPEG_ERASED_BYTE;
        end
        else
        begin
            state_next.core_rdata = array_rdata;
        end

        // External programmer sequencer.
        state_next.arr_rd    = 1'b0;
        state_next.arr_wr    = 1'b0;
        state_next.arr_erase = 1'b0;
        state_next.prom_done = 1'b0;
        case (state_reg.prom_st)
            FPEG_PROM_IDLE:
            begin
                if (prom_req && prom_s)
                begin
                    state_next.prom_op   = prom_op;
                    state_next.arr_addr  = prom_addr;
                    state_next.arr_wdata = prom_wdata;
                    state_next.arr_rd    = (prom_op == FPEG_OP_READ);
                    state_next.arr_wr    = (prom_op == FPEG_OP_WRITE);
                    state_next.arr_erase = (prom_op == FPEG_OP_ERASE);
                    state_next.prom_st   = FPEG_PROM_EXEC;
                end
            end
            FPEG_PROM_EXEC:
            begin
                state_next.prom_st = FPEG_PROM_DONE;
            end
            FPEG_PROM_DONE:
            begin
                if (state_reg.prom_op == FPEG_OP_READ)
                begin
                    state_next.prom_rdata = array_rdata;
                end
                else
                begin
                    state_next.prom_rdata = '0;
                end
                state_next.prom_done = 1'b1;
                irq_ev[FPEG_IRQ_PROM_BIT] = 1'b1;
                state_next.prom_st = FPEG_PROM_IDLE;
            end
            default:
            begin
                state_next.prom_st = FPEG_PROM_IDLE;
            end
        endcase

        // Sticky status, enable and clear; a new event wins over a clear.
        if (wr_en)
        begin
            state_next.irq_en = pwdata[FPEG_IRQ_W-1:0];
        end
        if (wr_clr)
        begin
            state_next.irq_stat = state_reg.irq_stat & ~pwdata[FPEG_IRQ_W-1:0];
        end
        state_next.irq_stat = state_next.irq_stat | irq_ev;
        state_next.irq      = |(state_next.irq_stat & state_next.irq_en);

        // APB read data and error answer.
        if (paddr == FPEG_OFF_CTRL)
        begin
            rd_val[FPEG_CTRL_SWE_BIT]   = state_reg.software_write_enable;
            rd_val[FPEG_CTRL_PROG_BIT]  = state_reg.prog;
            rd_val[FPEG_CTRL_ERASE_BIT] = state_reg.erase;
        end
        else if (paddr == FPEG_OFF_OVERLAY)
        begin
            rd_val[FPEG_OVL_EMUL_BIT] = state_reg.emul_sel;
            rd_val[FPEG_OVL_SEL_LSB +: FPEG_OVL_SEL_W] = state_reg.ovl_sel;
        end
        else if (paddr == FPEG_OFF_STATUS)
        begin
            rd_val[FPEG_ST_ERR_BIT]     = state_reg.err_flag;
            rd_val[FPEG_ST_PROG_BIT]    = state_reg.prog_act;
            rd_val[FPEG_ST_ERASE_BIT]   = state_reg.erase_act;
            rd_val[FPEG_ST_BOOT_BIT]    = boot_s && !state_reg.boot_branched;
            rd_val[FPEG_ST_MASK_BIT]    = !state_reg.nmi_out && nmi_s;
            rd_val[FPEG_ST_PROMBSY_BIT] = (state_reg.prom_st != FPEG_PROM_IDLE);
        end
        else if (paddr == FPEG_OFF_IRQ_STAT)
        begin
            rd_val[FPEG_IRQ_W-1:0] = state_reg.irq_stat;
        end
        else if (paddr == FPEG_OFF_IRQ_EN)
        begin
            rd_val[FPEG_IRQ_W-1:0] = state_reg.irq_en;
        end
        else if (paddr == FPEG_OFF_IRQ_CLR)
        begin
            rd_val = 32'h0000_0000;
        end
        else
        begin
            rd_err = 1'b1;
        end

        state_next.pready = setup_ph;
        if (setup_ph)
        begin
            state_next.prdata  = pwrite ? 32'h0000_0000 : rd_val;
            state_next.pslverr = rd_err;
        end
        else
        begin
            state_next.prdata  = 32'h0000_0000;
            state_next.pslverr = 1'b0;
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            state_reg         <= '0;
            state_reg.prom_st <= FPEG_PROM_IDLE;
        end
        else
        begin
            state_reg <= state_next;
        end
    end

    assign prdata               = state_reg.prdata;
    assign pready               = state_reg.pready;
    assign pslverr              = state_reg.pslverr;
    assign core_flash_rdata     = state_reg.core_rdata;
    assign nmi_to_core          = state_reg.nmi_out;
    assign irq                  = state_reg.irq;
    assign program_active       = state_reg.prog_act;
    assign erase_active         = state_reg.erase_act;
    assign overlay_enable       = state_reg.emul_sel;
    assign overlap_block_select = state_reg.ovl_sel;
    assign array_read           = state_reg.arr_rd;
    assign array_write          = state_reg.arr_wr;
    assign array_erase_all      = state_reg.arr_erase;
    assign array_addr           = state_reg.arr_addr;
    assign array_wdata          = state_reg.arr_wdata;
    assign prom_rdata           = state_reg.prom_rdata;
    assign prom_done            = state_reg.prom_done;
endmodule

/* File: fpeg_pkg.sv */
// Shared constants and types of the flash program/erase gating block, plus a
// level synchroniser for pin inputs.
// Assumes one clock, pclk, and an asynchronous active-low reset.
package fpeg_pkg;
    localparam logic [7:0] FPEG_OFF_CTRL     = 8'h00;
    localparam logic [7:0] FPEG_OFF_OVERLAY  = 8'h04;
    localparam logic [7:0] FPEG_OFF_STATUS   = 8'h08;
    localparam logic [7:0] FPEG_OFF_IRQ_STAT = 8'h0C;
    localparam logic [7:0] FPEG_OFF_IRQ_CLR  = 8'h10;
    localparam logic [7:0] FPEG_OFF_IRQ_EN   = 8'h14;
    localparam int FPEG_CTRL_PROG_BIT  = 0;
    localparam int FPEG_CTRL_ERASE_BIT = 1;
    localparam int FPEG_CTRL_SWE_BIT   = 6;
    localparam int FPEG_OVL_SEL_LSB    = 1;
    localparam int FPEG_OVL_EMUL_BIT   = 7;
    localparam int FPEG_ST_ERR_BIT     = 0;
    localparam int FPEG_ST_PROG_BIT    = 1;
    localparam int FPEG_ST_ERASE_BIT   = 2;
    localparam int FPEG_ST_BOOT_BIT    = 3;
    localparam int FPEG_ST_MASK_BIT    = 4;
    localparam int FPEG_ST_PROMBSY_BIT = 5;
    localparam int FPEG_IRQ_ERR_BIT    = 0;
    localparam int FPEG_IRQ_FORCE_BIT  = 1;
    localparam int FPEG_IRQ_PROM_BIT   = 2;
    localparam int FPEG_IRQ_W          = 3;
    localparam int FPEG_OVL_SEL_W      = 3;
    localparam logic [7:0] FPEG_ERASED_BYTE = 8'hFF;
    localparam logic [1:0] FPEG_OP_READ  = 2'h0;
    localparam logic [1:0] FPEG_OP_WRITE = 2'h1;
    localparam logic [1:0] FPEG_OP_ERASE = 2'h2;

    typedef enum logic [2:0]
    {
        FPEG_PROM_IDLE = 3'h1,
        FPEG_PROM_EXEC = 3'h2,
        FPEG_PROM_DONE = 3'h4
    } fpeg_prom_state_t;
endpackage

// Two flip-flop synchroniser, one chain per bit.
module fpeg_sync #(
    parameter int WIDTH = 1
) (
    // Clock and reset.
    input  wire logic             pclk,
    input  wire logic             presetn,
    // Asynchronous levels in, synchronised levels out.
    input  wire logic [WIDTH-1:0] async_in,
    output logic      [WIDTH-1:0] sync_out
);
    logic [WIDTH-1:0] meta_reg;

    // A chain of no bits cannot be built.
    if (WIDTH < 1)
    begin : g_bad_width
        $error("fpeg_sync: WIDTH must be at least 1.");
    end

    genvar i;
    generate
        for (i = 0; i < WIDTH; i++)
        begin : g_bit
            always_ff @(posedge pclk or negedge presetn)
            begin
                if (!presetn)
                begin
                    meta_reg[i] <= 1'b0;
                    sync_out[i] <= 1'b0;
                end
                else
                begin
                    meta_reg[i] <= async_in[i];
                    sync_out[i] <= meta_reg[i];
                end
            end
        end
    endgenerate
endmodule

/* File: fpeg_checker.sv */
// Concurrent assertions on the ports of the flash program/erase gating block.
// Assumes the fpeg_top port names and a single pclk domain with active-low reset.
module fpeg_checker
    import fpeg_pkg::*;
(
    // Clock and reset.
    input wire logic pclk,
    input wire logic presetn,
    // APB handshake.
    input wire logic psel,
    input wire logic penable,
    input wire logic pready,
    input wire logic pslverr,
    // Pins and core side.
    input wire logic flash_write_enable_pin,
    input wire logic standby_req,
    input wire logic core_flash_read,
    input wire logic nmi_to_core,
    // Array control and programmer port.
    input wire logic program_active,
    input wire logic erase_active,
    input wire logic overlay_enable,
    input wire logic array_read,
    input wire logic array_write,
    input wire logic array_erase_all,
    input wire logic prom_done
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    sequence apb_setup_s;
        psel && !penable;
    endsequence
    sequence array_op_s;
        array_read || array_write || array_erase_all;
    endsequence
    sequence pe_read_s;
        core_flash_read && program_active;
    endsequence

    emul_protect_a: assert property (overlay_enable |-> !program_active && !erase_active)
        else $error("Program or erase active while emulation selected.");
    pe_nmi_mask_a: assert property (program_active || erase_active |-> !nmi_to_core)
        else $error("Interrupt passed during program or erase.");
    err_nmi_mask_a: assert property (pe_read_s |=> !nmi_to_core [*8])
        else $error("Interrupt passed in error protection.");
    err_abort_a: assert property (pe_read_s |=> !program_active)
        else $error("Program mode not aborted after array read.");
    apb_ready_a: assert property (apb_setup_s |=> pready ##1 !pready)
        else $error("Ready not a single pulse after setup.");
    apb_err_a: assert property (pslverr |-> pready)
        else $error("Slave error without ready.");
    prom_done_a: assert property (array_op_s |-> ##2 prom_done)
        else $error("Programmer operation not completed in time.");
    pin_clear_a: assert property (!flash_write_enable_pin [*4] |=> !program_active && !erase_active)
        else $error("Program or erase left active with pin low.");
    standby_clear_a: assert property (standby_req [*2] |=> !program_active && !erase_active)
        else $error("Program or erase left active in standby.");
endmodule

bind fpeg_top fpeg_checker chk_i (.pclk, .presetn, .psel, .penable, .pready, .pslverr,
    .flash_write_enable_pin, .standby_req, .core_flash_read, .nmi_to_core, .program_active,
    .erase_active, .overlay_enable, .array_read, .array_write, .array_erase_all, .prom_done);

/* File: fpeg_array_model.sv */
// Behavioural flash array standing behind the array control outputs.
// Assumes byte-wide data, one-cycle read latency and the pclk of the block.
module fpeg_array_model
    import fpeg_pkg::*;
#(
    parameter int ADDR_W = 17
) (
    // Clock.
    input  wire logic              pclk,
    // Array control.
    input  wire logic              array_read,
    input  wire logic              array_write,
    input  wire logic              array_erase_all,
    input  wire logic [ADDR_W-1:0] array_addr,
    input  wire logic [7:0]        array_wdata,
    // Read data.
    output logic      [7:0]        array_rdata
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [7:0] mem [256];
    initial
    begin
        foreach (mem[i]) mem[i] = FPEG_ERASED_BYTE;
        array_rdata = 8'h00;
    end
    // Read data is valid for one cycle only and flips every cycle otherwise.
    always @(posedge pclk)
    begin
        if (array_erase_all) foreach (mem[i]) mem[i] <= FPEG_ERASED_BYTE;
        if (array_write) mem[array_addr[7:0]] <= array_wdata;
        array_rdata <= array_read ? mem[array_addr[7:0]] : ~array_rdata;
    end
endmodule

/* File: tb.sv */
// Self-checking bench for the gating block with a flash array model.
// Assumes fpeg_pkg, fpeg_top, the array model and the checker compiled first.
module tb;
    timeunit 1ns;
    timeprecision 1ps;
    import fpeg_pkg::*;
    logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
    logic [7:0]  paddr;
    logic [31:0] pwdata, prdata, rnd;
    logic        flash_write_enable_pin, nmi_pin, boot_mode_pin, prom_mode_pin;
    logic        standby_req, boot_branch_done, core_flash_read, nmi_to_core, irq;
    logic        program_active, erase_active, overlay_enable, array_read, array_write;
    logic        array_erase_all, prom_req, prom_done;
    logic [2:0]  overlap_block_select;
    logic [1:0]  prom_op;
    logic [16:0] array_addr, prom_addr;
    logic [7:0]  array_rdata, core_flash_rdata, array_wdata, prom_wdata, prom_rdata;
    logic [32:0] apb_q[$];
    logic [7:0]  prom_q[$];
    logic [7:0]  offs [6] = '{FPEG_OFF_CTRL, FPEG_OFF_OVERLAY, FPEG_OFF_STATUS,
                              FPEG_OFF_IRQ_STAT, FPEG_OFF_IRQ_CLR, FPEG_OFF_IRQ_EN};
    int          bad_count, checks_done, seed;

    fpeg_top dut (.*);
    fpeg_array_model mdl (.*);

    initial
    begin
        pclk = 1'b0;
        forever #4 pclk = ~pclk;
    end

    task automatic chk(input logic [32:0] got, input logic [32:0] exp);
        checks_done++;
        if (got !== exp)
        begin
            bad_count++;
            $display("[FAIL] %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge pclk);
    endtask
    task automatic wrap_up();
        if (bad_count == 0 && checks_done > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask
    task automatic await(input bit on_prom);
        int n;
        n = 0;
        do
        begin
            @(posedge pclk);
            n++;
        end
        while ((on_prom ? prom_done : pready) !== 1'b1 && n < 16);
        if ((on_prom ? prom_done : pready) !== 1'b1)
        begin
            bad_count++;
            wrap_up();
        end
    endtask
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                       input logic [32:0] e);
        apb_q.push_back(e);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        await(1'b0);
        psel <= 1'b0;
        penable <= 1'b0;
        tick(2);
    endtask
    task automatic prom(input logic [1:0] op, input logic [7:0] d, input logic [7:0] e);
        prom_q.push_back(e);
        prom_req <= 1'b1;
        prom_op <= op;
        prom_addr <= 17'h00010;
        prom_wdata <= d;
        @(posedge pclk);
        prom_req <= 1'b0;
        await(1'b1);
        tick(1);
    endtask
    task automatic do_reset();
        presetn <= 1'b0;
        tick(2);
        presetn <= 1'b1;
        tick(4);
    endtask

    // Each answer is compared with the oldest expectation noted by the driver.
    always @(posedge pclk)
    begin
        if (psel && penable && pready === 1'b1)
            chk({pslverr, prdata}, apb_q.pop_front());
        if (prom_done === 1'b1)
            chk({25'h0, prom_rdata}, {25'h0, prom_q.pop_front()});
    end

    initial
    begin
        seed = 32'hd564a76c;
        bad_count = 0;
        checks_done = 0;
        {presetn, psel, penable, pwrite, paddr, pwdata} = '0;
        {flash_write_enable_pin, nmi_pin, boot_mode_pin, prom_mode_pin, standby_req} = '0;
        {boot_branch_done, core_flash_read, prom_req, prom_op, prom_addr, prom_wdata} = '0;
        do_reset();
        foreach (offs[i]) apb(1'b0, offs[i], 32'h0, 33'h0);
        apb(1'b0, 8'h18, 32'h0, {1'b1, 32'h0});
        apb(1'b1, 8'h1C, 32'hFF, {1'b1, 32'h0});
        flash_write_enable_pin <= 1'b1;
        nmi_pin <= 1'b1;
        tick(4);
        chk(nmi_to_core, 1'b1);
        apb(1'b1, FPEG_OFF_CTRL, 32'h41, 33'h0);
        chk({program_active, nmi_to_core}, 2'b10);
        apb(1'b0, FPEG_OFF_STATUS, 32'h0, 33'h12);
        apb(1'b1, FPEG_OFF_CTRL, 32'h42, 33'h0);
        chk({program_active, erase_active, nmi_to_core}, 3'b010);
        apb(1'b1, FPEG_OFF_CTRL, 32'h02, 33'h0);
        apb(1'b0, FPEG_OFF_CTRL, 32'h0, 33'h0);
        apb(1'b0, FPEG_OFF_IRQ_STAT, 32'h0, 33'h2);
        chk(nmi_to_core, 1'b1);
        apb(1'b1, FPEG_OFF_IRQ_EN, 32'h2, 33'h0);
        chk(irq, 1'b1);
        apb(1'b1, FPEG_OFF_IRQ_EN, 32'h0, 33'h0);
        chk(irq, 1'b0);
        apb(1'b1, FPEG_OFF_IRQ_EN, 32'h2, 33'h0);
        apb(1'b1, FPEG_OFF_IRQ_CLR, 32'h2, 33'h0);
        chk(irq, 1'b0);
        apb(1'b0, FPEG_OFF_IRQ_EN, 32'h0, 33'h2);
        apb(1'b1, FPEG_OFF_CTRL, 32'h41, 33'h0);
        flash_write_enable_pin <= 1'b0;
        tick(5);
        chk(program_active, 1'b0);
        flash_write_enable_pin <= 1'b1;
        tick(3);
        apb(1'b1, FPEG_OFF_CTRL, 32'h41, 33'h0);
        standby_req <= 1'b1;
        tick(3);
        chk(program_active, 1'b0);
        standby_req <= 1'b0;
        apb(1'b1, FPEG_OFF_CTRL, 32'h41, 33'h0);
        do_reset();
        chk(program_active, 1'b0);
        apb(1'b0, FPEG_OFF_CTRL, 32'h0, 33'h0);
        for (int i = 0; i < 8; i++)
        begin
            apb(1'b1, FPEG_OFF_OVERLAY, {24'h0, 1'b1, 3'h0, i[2:0], 1'b0}, 33'h0);
            chk({overlay_enable, overlap_block_select}, {1'b1, i[2:0]});
        end
        apb(1'b1, FPEG_OFF_CTRL, 32'h41, 33'h0);
        chk({program_active, nmi_to_core}, 2'b00);
        apb(1'b1, FPEG_OFF_OVERLAY, 32'h0, 33'h0);
        chk(program_active, 1'b1);
        core_flash_read <= 1'b1;
        tick(1);
        core_flash_read <= 1'b0;
        tick(3);
        chk({program_active, nmi_to_core}, 2'b00);
        apb(1'b0, FPEG_OFF_STATUS, 32'h0, 33'h11);
        apb(1'b1, FPEG_OFF_CTRL, 32'h40, 33'h0);
        chk(nmi_to_core, 1'b0);
        apb(1'b0, FPEG_OFF_IRQ_STAT, 32'h0, 33'h1);
        boot_mode_pin <= 1'b1;
        do_reset();
        chk(nmi_to_core, 1'b0);
        apb(1'b0, FPEG_OFF_STATUS, 32'h0, 33'h18);
        boot_branch_done <= 1'b1;
        tick(1);
        boot_branch_done <= 1'b0;
        tick(2);
        chk(nmi_to_core, 1'b1);
        apb(1'b1, FPEG_OFF_CTRL, 32'h42, 33'h0);
        chk(nmi_to_core, 1'b0);
        chk(core_flash_rdata, FPEG_ERASED_BYTE);
        prom_mode_pin <= 1'b1;
        tick(3);
        rnd = $random(seed);
        prom(FPEG_OP_READ, 8'h00, FPEG_ERASED_BYTE);
        prom(FPEG_OP_WRITE, rnd[7:0], 8'h00);
        prom(FPEG_OP_READ, 8'h00, rnd[7:0]);
        prom(FPEG_OP_ERASE, 8'h00, 8'h00);
        prom(FPEG_OP_READ, 8'h00, FPEG_ERASED_BYTE);
        prom(2'h3, 8'h00, 8'h00);
        wrap_up();
    end
endmodule
